// ===== rtl/hbridge_pkg.sv
// Constants, register layout and types for the H-bridge drive control block
`default_nettype none

package hbridge_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;  // power_stage_ctrl_reg
    localparam logic [7:0] ADDR_IRQ_ST = 8'h04;  // sticky event status
    localparam logic [7:0] ADDR_IRQ_MK = 8'h08;  // event mask

    // Control register bit positions
    localparam int B_EN   = 0;
    localparam int B_PWM  = 1;
    localparam int B_IN1  = 2;
    localparam int B_IN2  = 3;
    localparam int B_DIR  = 4;
    localparam int B_SC   = 5;
    localparam int B_OVT  = 6;
    localparam int B_PIE  = 7;

    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [7:0]  CTRL_WMASK = 8'h9F;  // flags are read only
    localparam logic [1:0]  EVT_RESET  = 2'h0;
    localparam int          EVT_SC     = 0;
    localparam int          EVT_OVT    = 1;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Driving modes
    typedef enum logic [2:0] {
        MODE_OFF    = 3'b000,
        MODE_DIRECT = 3'b001,
        MODE_UPBRK  = 3'b010,
        MODE_DNBRK  = 3'b011,
        MODE_SYMM   = 3'b100,
        MODE_DUAL   = 3'b101
    } drive_mode_t;

    // Gate drives of one half bridge
    typedef struct packed {
        logic high;
        logic low;
    } half_drive_t;

    // Both half bridges
    typedef struct packed {
        half_drive_t left_half;
        half_drive_t right_half;
    } gate_drive_t;

endpackage

`default_nettype wire

// ===== rtl/h_bridge_drive_control.sv
// H-bridge gate drive control with AXI4-Lite register access
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

module h_bridge_drive_control (
    input  wire logic                      I_CLK_SYS,        // System clock 100 MHz
    input  wire logic                      I_RESET_N,        // Sync reset, active low
    // AXI4-Lite slave
    input  wire logic [7:0]                I_AWADDR,         // Write address
    input  wire logic                      I_AWVALID,        // Write address valid
    output logic                           O_AWREADY,        // Write address ready
    input  wire logic [31:0]               I_WDATA,          // Write data
    input  wire logic [3:0]                I_WSTRB,          // Write strobes
    input  wire logic                      I_WVALID,         // Write data valid
    output logic                           O_WREADY,         // Write data ready
    output logic [1:0]                     O_BRESP,          // Write response
    output logic                           O_BVALID,         // Write response valid
    input  wire logic                      I_BREADY,         // Write response ready
    input  wire logic [7:0]                I_ARADDR,         // Read address
    input  wire logic                      I_ARVALID,        // Read address valid
    output logic                           O_ARREADY,        // Read address ready
    output logic [31:0]                    O_RDATA,          // Read data
    output logic [1:0]                     O_RRESP,          // Read response
    output logic                           O_RVALID,         // Read data valid
    input  wire logic                      I_RREADY,         // Read data ready
    // PWM sources and fault detectors
    input  wire logic                      I_PWM_SOURCE_A,   // First PWM line
    input  wire logic                      I_PWM_SOURCE_B,   // Second PWM line
    input  wire logic [3:0]                I_SC_DETECT,      // Per-switch overcurrent
    input  wire logic                      I_OVERTEMP,       // Thermal detector
    input  wire hbridge_pkg::gate_drive_t  I_GATE_SENSE,     // Sensed gate on states
    // Power stage
    output hbridge_pkg::gate_drive_t       O_GATE_DRIVE,     // Four gate drives
    output logic                           O_OUTPUT_EN,      // Low: outputs floating
    output logic                           O_FAULT_IRQ,      // Bridge fault request
    output logic                           O_IRQ             // Masked event interrupt
);
    import hbridge_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0]  ctrl_q, ctrl_d;
    logic [1:0]  evt_q, evt_d;
    logic [1:0]  mask_q, mask_d;
    logic        sc_q, ovt_q;
    logic        sc_s1_q, sc_s2_q, ot_s1_q, ot_s2_q;
    logic        pwm_a_q, pwm_b_q;
    logic        dir_a_q, dir_b_q;
    logic        pie_q;
    gate_drive_t want_q, drive_q;

    // Control field views
    wire en_bit  = ctrl_q[B_EN];
    wire pwm_en  = ctrl_q[B_PWM];
    wire in1_bit = ctrl_q[B_IN1];
    wire in2_bit = ctrl_q[B_IN2];
    wire dir_bit = ctrl_q[B_DIR];

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data taken in either order
    logic        aw_held_q, w_held_q, bvalid_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic [1:0]  bresp_q;

    wire         aw_take  = I_AWVALID && !aw_held_q && !bvalid_q;
    wire         w_take   = I_WVALID && !w_held_q && !bvalid_q;
    wire         wr_do    = aw_held_q && w_held_q && !bvalid_q;
    wire         wr_ok    = (awaddr_q == ADDR_CTRL) || (awaddr_q == ADDR_IRQ_ST)
                            || (awaddr_q == ADDR_IRQ_MK);
    wire         wr_byte0 = wr_do && wstrb_q[0];
    wire         wr_ctrl  = wr_byte0 && (awaddr_q == ADDR_CTRL);
    wire         wr_st    = wr_byte0 && (awaddr_q == ADDR_IRQ_ST);
    wire         wr_mk    = wr_byte0 && (awaddr_q == ADDR_IRQ_MK);

    assign O_AWREADY = !aw_held_q && !bvalid_q;
    assign O_WREADY  = !w_held_q && !bvalid_q;
    assign O_BVALID  = bvalid_q;
    assign O_BRESP   = bresp_q;

    // Write channel holding and response
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= I_AWADDR;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wdata_q  <= I_WDATA;
                wstrb_q  <= I_WSTRB;
            end
            if (wr_do) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && I_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path, one cycle to answer
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    wire         ar_take = I_ARVALID && !rvalid_q;
    wire         rd_ctrl = I_ARADDR == ADDR_CTRL;
    wire         rd_st   = I_ARADDR == ADDR_IRQ_ST;
    wire         rd_mk   = I_ARADDR == ADDR_IRQ_MK;
    wire [7:0]   ctrl_view = {ctrl_q[7], ovt_q, sc_q, ctrl_q[4:0]};
    wire [31:0]  rd_mux  = rd_ctrl ? {24'h000000, ctrl_view} :
                           rd_st   ? {30'h00000000, evt_q} :
                           rd_mk   ? {30'h00000000, mask_q} : 32'h0000_0000;

    assign O_ARREADY = !rvalid_q;
    assign O_RVALID  = rvalid_q;
    assign O_RDATA   = rdata_q;
    assign O_RRESP   = rresp_q;

    // Read data capture
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= (rd_ctrl || rd_st || rd_mk) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && I_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault detection, synchronised first
    wire sc_any    = |I_SC_DETECT;
    wire sc_set    = en_bit && sc_s2_q;
    wire ovt_set   = en_bit && ot_s2_q;
    wire fault     = sc_q || ovt_q;
    wire sc_rise   = sc_set && !sc_q;
    wire ovt_rise  = ovt_set && !ovt_q;

    // Two-flop synchronisers; detectors are asynchronous analogue signals
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            sc_s1_q <= 1'b0;
            sc_s2_q <= 1'b0;
            ot_s1_q <= 1'b0;
            ot_s2_q <= 1'b0;
        end else begin
            sc_s1_q <= sc_any;
            sc_s2_q <= sc_s1_q;
            ot_s1_q <= I_OVERTEMP;
            ot_s2_q <= ot_s1_q;
        end
    end

    // Flags stick until enable goes low; enable low also blocks a set in that cycle
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            sc_q  <= 1'b0;
            ovt_q <= 1'b0;
        end else begin
            sc_q  <= sc_set || (sc_q && en_bit);
            ovt_q <= ovt_set || (ovt_q && en_bit);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register and fault interrupt request
    assign ctrl_d = wr_ctrl ? ((wdata_q[7:0] & CTRL_WMASK) | (ctrl_q & ~CTRL_WMASK))
                            : ctrl_q;
    wire pie_on   = ctrl_q[B_PIE];
    wire pie_arm  = wr_ctrl && wdata_q[B_PIE] && !pie_on;

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            ctrl_q <= CTRL_RESET;
            pie_q  <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            // Request drops when enable clears
            if (!en_bit)
                pie_q <= 1'b0;
            else if (pie_on && (sc_rise || ovt_rise))
                pie_q <= 1'b1;
            else if (pie_arm && fault)
                pie_q <= 1'b1;
        end
    end
    assign O_FAULT_IRQ = pie_q;

    ////////////////////////////////////////////////////////////////////////////
    // Event status and mask; write one clears, set beats clear
    assign evt_d  = ({ovt_rise, sc_rise}) | (evt_q & ~(wr_st ? wdata_q[1:0] : 2'h0));
    assign mask_d = wr_mk ? wdata_q[1:0] : mask_q;

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            evt_q  <= EVT_RESET;
            mask_q <= EVT_RESET;
        end else begin
            evt_q  <= evt_d;
            mask_q <= mask_d;
        end
    end
    assign O_IRQ = |(evt_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // Direction latched on rising PWM edges only
    wire pwm_a_rise = I_PWM_SOURCE_A && !pwm_a_q;
    wire pwm_b_rise = I_PWM_SOURCE_B && !pwm_b_q;

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            pwm_a_q <= 1'b0;
            pwm_b_q <= 1'b0;
            dir_a_q <= 1'b0;
            dir_b_q <= 1'b0;
        end else begin
            pwm_a_q <= I_PWM_SOURCE_A;
            pwm_b_q <= I_PWM_SOURCE_B;
            if (pwm_a_rise)
                dir_a_q <= dir_bit;
            if (pwm_b_rise)
                dir_b_q <= dir_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode and drive table
    drive_mode_t mode;
    gate_drive_t want_d;
    wire         pa = I_PWM_SOURCE_A;
    wire         pb = I_PWM_SOURCE_B;

    assign mode = !en_bit                ? MODE_OFF    :
                  !pwm_en                ? MODE_DIRECT :
                  (!in1_bit && !in2_bit) ? MODE_UPBRK  :
                  (!in1_bit &&  in2_bit) ? MODE_DNBRK  :
                  ( in1_bit && !in2_bit) ? MODE_SYMM   : MODE_DUAL;

    // Half drive from a level: high on when level is 1, low otherwise
    function automatic half_drive_t half_of(input logic lvl);
        half_of.high = lvl;
        half_of.low  = !lvl;
    endfunction

    always_comb begin
        want_d = '0;
        case (mode)
            MODE_DIRECT: begin
                want_d.left_half  = half_of(in1_bit);
                want_d.right_half = half_of(in2_bit);
            end
            MODE_UPBRK: begin
                // Left held high when forward, right held high when back
                want_d.left_half  = half_of(!dir_a_q || !pa);
                want_d.right_half = half_of(dir_a_q || !pa);
            end
            MODE_DNBRK: begin
                // Brake with both lows on while PWM is low
                want_d.left_half  = half_of(!dir_a_q && pa);
                want_d.right_half = half_of(dir_a_q && pa);
            end
            MODE_SYMM: begin
                want_d.left_half  = half_of(pa ^ dir_a_q);
                want_d.right_half = half_of(!(pa ^ dir_a_q));
            end
            MODE_DUAL: begin
                want_d.left_half  = half_of(pa);
                want_d.right_half = half_of(pb);
            end
            default: want_d = '0;
        endcase
        if (fault || sc_set || ovt_set)
            want_d = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cross-conduction guard: a switch turns on only when its partner senses off
    gate_drive_t drive_d;
    always_comb begin
        drive_d = want_q;
        // Turn-on waits on the sensed gate, so the delay is not fixed
        if (want_q.left_half.low && I_GATE_SENSE.left_half.high)
            drive_d.left_half.low = 1'b0;
        if (want_q.left_half.high && I_GATE_SENSE.left_half.low)
            drive_d.left_half.high = 1'b0;
        if (want_q.right_half.low && I_GATE_SENSE.right_half.high)
            drive_d.right_half.low = 1'b0;
        if (want_q.right_half.high && I_GATE_SENSE.right_half.low)
            drive_d.right_half.high = 1'b0;
        if (drive_q.left_half.high)
            drive_d.left_half.low = 1'b0;
        if (drive_q.left_half.low)
            drive_d.left_half.high = 1'b0;
        if (drive_q.right_half.high)
            drive_d.right_half.low = 1'b0;
        if (drive_q.right_half.low)
            drive_d.right_half.high = 1'b0;
    end

    // Registered drives; faults cut the want stage combinationally too
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            want_q  <= '0;
            drive_q <= '0;
        end else begin
            want_q  <= want_d;
            drive_q <= (fault || sc_set || ovt_set || !en_bit) ? '0 : drive_d;
        end
    end

    assign O_GATE_DRIVE = drive_q;
    assign O_OUTPUT_EN  = en_bit;

endmodule

`default_nettype wire

// ===== verif/h_bridge_drive_control_chk.sv
// Port-level assertions for the H-bridge drive control block
`timescale 1ns/1ps
`default_nettype none
module h_bridge_drive_control_chk (
    input wire logic                     I_CLK_SYS,    // Clock
    input wire logic                     I_RESET_N,    // Reset
    input wire logic                     O_AWREADY,    // AW ready
    input wire logic                     O_WREADY,     // W ready
    input wire logic [1:0]               O_BRESP,      // B response
    input wire logic                     O_BVALID,     // B valid
    input wire logic                     I_BREADY,     // B ready
    input wire logic [31:0]              O_RDATA,      // R data
    input wire logic                     O_RVALID,     // R valid
    input wire logic                     I_RREADY,     // R ready
    input wire logic [3:0]               I_SC_DETECT,  // Overcurrent
    input wire logic                     I_OVERTEMP,   // Thermal
    input wire hbridge_pkg::gate_drive_t I_GATE_SENSE, // Sensed gates
    input wire hbridge_pkg::gate_drive_t O_GATE_DRIVE, // Gate drives
    input wire logic                     O_OUTPUT_EN,  // Outputs enabled
    input wire logic                     O_FAULT_IRQ   // Fault request
);
    import hbridge_pkg::*;
    wire fault_in = (|I_SC_DETECT) || I_OVERTEMP;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESET_N);
    ////////////////////////////////////////////////////////////////
    // Detector held past the two sync stages and the flag stage
    sequence fault_held_s;
        (fault_in && O_OUTPUT_EN) [*4];
    endsequence
    // Enable low long enough to flush the drive pipeline
    sequence en_off_s;
        !O_OUTPUT_EN [*3];
    endsequence
    ////////////////////////////////////////////////////////////////
    // Gate drive safety
    no_cross_a: assert property (
        !(O_GATE_DRIVE.left_half.high && O_GATE_DRIVE.left_half.low) &&
        !(O_GATE_DRIVE.right_half.high && O_GATE_DRIVE.right_half.low))
        else $error("Both switches of a half bridge on");
    left_sense_a: assert property (
        ($rose(O_GATE_DRIVE.left_half.low) |-> !$past(I_GATE_SENSE.left_half.high)) and
        ($rose(O_GATE_DRIVE.left_half.high) |-> !$past(I_GATE_SENSE.left_half.low)))
        else $error("Left switch on while its partner sensed on");
    right_sense_a: assert property (
        ($rose(O_GATE_DRIVE.right_half.low) |-> !$past(I_GATE_SENSE.right_half.high)) and
        ($rose(O_GATE_DRIVE.right_half.high) |-> !$past(I_GATE_SENSE.right_half.low)))
        else $error("Right switch on while its partner sensed on");
    reset_state_a: assert property ($rose(I_RESET_N) |->
        O_GATE_DRIVE == 4'h0 && !O_OUTPUT_EN && !O_FAULT_IRQ && !O_BVALID && !O_RVALID)
        else $error("Outputs not safe after reset");
    enable_off_a: assert property (en_off_s |-> O_GATE_DRIVE == 4'h0)
        else $error("Drive on while disabled");
    fault_off_a: assert property (fault_held_s |-> O_GATE_DRIVE == 4'h0)
        else $error("Drive on during fault");
    // Request drops one edge after enable is seen low; enable may already be back
    irq_sticky_a: assert property ($fell(O_FAULT_IRQ) |-> !$past(O_OUTPUT_EN))
        else $error("Fault request dropped while enabled");
    // Bus handshake stability
    bresp_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("Write response not held");
    rdata_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("Read data not held");
    ready_block_a: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
        else $error("Write accepted while response pending");
endmodule
`default_nettype wire

// ===== verif/hbridge_load_model.sv
// Load and gate sense model for the H-bridge power stage
`timescale 1ns/1ps
`default_nettype none
module hbridge_load_model
    import hbridge_pkg::*;
#(
    parameter int SENSE_DLY = 3                      // Gate discharge cycles
) (
    input  wire logic                     i_clk,       // System clock
    input  wire logic                     i_reset_n,   // Sync reset
    input  wire hbridge_pkg::gate_drive_t i_drive,     // Gate drives
    input  wire logic                     i_short,     // Output shorted
    output var hbridge_pkg::gate_drive_t  o_sense,     // Sensed gate on
    output var logic [3:0]                o_sc_detect  // Overcurrent
);
    gate_drive_t hist_q [SENSE_DLY];
    // Gate charge history; slow discharge is the cross-conduction hazard
    always_ff @(posedge i_clk) begin
        hist_q[0] <= i_reset_n ? i_drive : '0;
        for (int k = 1; k < SENSE_DLY; k++) begin
            hist_q[k] <= hist_q[k - 1];
        end
    end
    // Sensed on one cycle after drive, off only after full discharge
    always_comb begin
        o_sense = '0;
        for (int k = 0; k < SENSE_DLY; k++) begin
            o_sense = o_sense | hist_q[k];
        end
    end
    // Short held on the left high switch detector
    assign o_sc_detect = i_short ? 4'h8 : 4'h0;
endmodule
`default_nettype wire

// ===== verif/h_bridge_drive_control_tb.sv
// Self-checking bench for the H-bridge drive control block
`timescale 1ns/1ps
`default_nettype none
module h_bridge_drive_control_tb;
    import hbridge_pkg::*;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, pwm_a, pwm_b;
    logic        awready, wready, bvalid, arready, rvalid, overtemp_flag, short_cmd;
    logic        out_en, fault_irq, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, sc_det;
    logic [1:0]  bresp, rresp;
    gate_drive_t sense, drive;
    int          mismatches, checks_done;
    ////////////////////////////////////////////////////////////////
    initial clk = 1'b0;
    always #5 clk = ~clk;
    h_bridge_drive_control i_dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n),
        .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
        .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
        .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
        .I_RREADY(rready), .I_PWM_SOURCE_A(pwm_a), .I_PWM_SOURCE_B(pwm_b),
        .I_SC_DETECT(sc_det), .I_OVERTEMP(overtemp_flag), .I_GATE_SENSE(sense),
        .O_GATE_DRIVE(drive), .O_OUTPUT_EN(out_en), .O_FAULT_IRQ(fault_irq), .O_IRQ(irq));
    hbridge_load_model i_load (.i_clk(clk), .i_reset_n(rst_n), .i_drive(drive),
        .i_short(short_cmd), .o_sense(sense), .o_sc_detect(sc_det));
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic guard(input int n);
        if (n >= 50) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Drive latency varies with gate sensing, so poll under a bound
    task automatic cmp_drive(input logic [3:0] exp);
        int n = 0;
        tick(3);
        while (drive !== exp && n < 50) begin
            @(posedge clk);
            n++;
        end
        cmp_reg({28'h0, drive}, {28'h0, exp});
        guard(n);
    endtask
    // AXI4-Lite write; address and data offered together
    // Response readies stay high after a transfer; every call still assigns its ready again before starting
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        guard(n);
        cmp_reg({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        guard(n);
        cmp_reg(rdata, ed);
        cmp_reg({30'h0, rresp}, {30'h0, er});
    endtask
    // Expected gates {left high, left low, right high, right low}
    function automatic logic [3:0] exp_drive(input logic i1, i2, pe, dr, pa, pb);
        if (!pe) return {i1, !i1, i2, !i2};
        case ({i2, i1})
            2'b00:   return pa ? (dr ? 4'h6 : 4'h9) : 4'hA;
            2'b10:   return pa ? (dr ? 4'h6 : 4'h9) : 4'h5;
            2'b01:   return (pa ^ dr) ? 4'h9 : 4'h6;
            default: return {pa, !pa, pb, !pb};
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, pwm_a, pwm_b, overtemp_flag, short_cmd} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        mismatches = 0;
        checks_done = 0;
        tick(2);
        rst_n <= 1'b1;
        @(posedge clk);
        // Reset values, unmapped place refused
        axi_read(ADDR_CTRL, {24'h0, CTRL_RESET}, RESP_OKAY);
        axi_read(ADDR_IRQ_ST, 32'h0, RESP_OKAY);
        axi_read(ADDR_IRQ_MK, 32'h0, RESP_OKAY);
        axi_read(8'h0C, 32'h0, RESP_SLVERR);
        axi_write(8'h0C, 32'hFF, RESP_SLVERR);
        cmp_reg({31'h0, out_en}, 32'h0);
        // Direct mode, every command pair
        for (int m = 0; m < 4; m++) begin
            axi_write(ADDR_CTRL, 32'h1 | 32'(m << B_IN1), RESP_OKAY);
            cmp_drive(exp_drive(m[0], m[1], 1'b0, 1'b0, pwm_a, pwm_b));
        end
        // PWM modes, both directions, both phases; line B runs opposite to A
        for (int m = 0; m < 8; m++) begin
            axi_write(ADDR_CTRL, 32'h3 | 32'((m & 3) << B_IN1) | 32'((m >> 2) << B_DIR),
                RESP_OKAY);
            pwm_a <= 1'b0;
            pwm_b <= 1'b1;
            tick(3);
            pwm_a <= 1'b1;
            pwm_b <= 1'b0;
            cmp_drive(exp_drive(m[0], m[1], 1'b1, m[2], 1'b1, 1'b0));
            pwm_a <= 1'b0;
            pwm_b <= 1'b1;
            cmp_drive(exp_drive(m[0], m[1], 1'b1, m[2], 1'b0, 1'b1));
        end
        // Direction written mid-pulse waits for the next rising edge
        axi_write(ADDR_CTRL, 32'h07, RESP_OKAY);
        pwm_a <= 1'b1;
        cmp_drive(4'h9);
        axi_write(ADDR_CTRL, 32'h17, RESP_OKAY);
        pwm_a <= 1'b0;
        cmp_drive(4'h6);
        pwm_a <= 1'b1;
        cmp_drive(4'h6);
        // Enable low forces all off
        axi_write(ADDR_CTRL, 32'h16, RESP_OKAY);
        cmp_drive(4'h0);
        axi_read(ADDR_CTRL, 32'h16, RESP_OKAY);
        cmp_reg({31'h0, out_en}, 32'h0);
        // Short circuit with request enabled and event unmasked
        axi_write(ADDR_IRQ_MK, 32'h1, RESP_OKAY);
        axi_write(ADDR_CTRL, 32'h85, RESP_OKAY);
        cmp_drive(4'h9);
        short_cmd <= 1'b1;
        cmp_drive(4'h0);
        short_cmd <= 1'b0;
        axi_read(ADDR_CTRL, 32'hA5, RESP_OKAY);
        cmp_reg({30'h0, fault_irq, irq}, 32'h3);
        axi_write(ADDR_CTRL, 32'h85, RESP_OKAY);
        tick(5);
        cmp_reg({28'h0, drive}, 32'h0);
        axi_write(ADDR_IRQ_ST, 32'h1, RESP_OKAY);
        axi_read(ADDR_IRQ_ST, 32'h0, RESP_OKAY);
        cmp_reg({31'h0, irq}, 32'h0);
        axi_write(ADDR_CTRL, 32'h84, RESP_OKAY);
        axi_read(ADDR_CTRL, 32'h84, RESP_OKAY);
        cmp_reg({31'h0, fault_irq}, 32'h0);
        axi_write(ADDR_CTRL, 32'h85, RESP_OKAY);
        cmp_drive(4'h9);
        // Overtemperature in a PWM mode, masked, request armed afterwards
        axi_write(ADDR_IRQ_MK, 32'h0, RESP_OKAY);
        axi_write(ADDR_CTRL, 32'h03, RESP_OKAY);
        overtemp_flag <= 1'b1;
        tick(5);
        overtemp_flag <= 1'b0;
        cmp_drive(4'h0);
        axi_read(ADDR_CTRL, 32'h43, RESP_OKAY);
        axi_read(ADDR_IRQ_ST, 32'h2, RESP_OKAY);
        cmp_reg({30'h0, fault_irq, irq}, 32'h0);
        axi_write(ADDR_CTRL, 32'h83, RESP_OKAY);
        tick(2);
        cmp_reg({31'h0, fault_irq}, 32'h1);
        axi_write(ADDR_IRQ_MK, 32'h2, RESP_OKAY);
        cmp_reg({31'h0, irq}, 32'h1);
        axi_write(ADDR_CTRL, 32'h0, RESP_OKAY);
        tick(2);
        cmp_reg({31'h0, fault_irq}, 32'h0);
        close_out();
    end
endmodule
bind h_bridge_drive_control h_bridge_drive_control_chk i_chk (.I_CLK_SYS(I_CLK_SYS),
    .I_RESET_N(I_RESET_N), .O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
    .I_RREADY(I_RREADY), .I_SC_DETECT(I_SC_DETECT), .I_OVERTEMP(I_OVERTEMP),
    .I_GATE_SENSE(I_GATE_SENSE), .O_GATE_DRIVE(O_GATE_DRIVE), .O_OUTPUT_EN(O_OUTPUT_EN),
    .O_FAULT_IRQ(O_FAULT_IRQ));
`default_nettype wire
